//--- design/host_port_pkg.sv
// How it works
// - two 32-bit address regs feed dma
// - single mode address write loads both
// - single mode increment bumps both registers
// - single mode address read returns read reg
// - host reloads addresses after mode changes
// - dual mode select bit picks register
// - select bit never steers dma
// - dual mode increments used register only
// - host loads word aligned addresses
// - host configures, loads address, then data
// - controls captured on strobe falling edge
// - read fetches memory, drives bus, ready
// - host captures data, then releases strobe
// - write latched on strobe rise, then stored
// - ready held off while resources busy
// - strobe from select and data strobes
// - ready forced low when deselected
// - single strobe host ties other input
// - chip select alone never strobes
// - code 00 ctl,01 inc,10 addr,11 data
// - direction high read, low write
// - ready low lets host complete
package host_port_pkg;
	localparam int DATA_W = 32;
	localparam int MEM_AW = 8;
	localparam int MEM_WORDS = 256;
	localparam logic [1:0] SEL_CTL = 2'h0;
	localparam logic [1:0] SEL_DATA_INC = 2'h1;
	localparam logic [1:0] SEL_ADDR = 2'h2;
	localparam logic [1:0] SEL_DATA = 2'h3;
	localparam int HALFWORD_ORDER_POS = 0;
	localparam int DUAL_MODE_POS = 1;
	localparam int ADDR_SELECT_POS = 2;
	localparam logic [2:0] CTL_RESET = 3'h0;
	localparam logic [31:0] ADDR_RESET = 32'h0;
	localparam int MEM_LATENCY = 2;
	localparam logic [1:0] MEM_LAT_CNT = 2'(MEM_LATENCY);
	localparam int STROBE_HALF = 2;
	localparam logic [1:0] STROBE_HALF_CNT = 2'(STROBE_HALF);
endpackage

//--- design/host_port_if.sv
`timescale 1ns/1ns
`default_nettype none
interface host_port_if;
	logic        chip_select_n;
	logic        data_strobe_a;
	logic        data_strobe_b;
	logic        direction_input;
	logic [1:0]  register_select_code;
	logic [31:0] host_data_out;
	logic        host_data_oe;
	logic [31:0] dev_data_out;
	logic        dev_data_oe;
	logic        ready_output;
	wire  [31:0] host_data_bus;
	assign host_data_bus = dev_data_oe ? dev_data_out :
		(host_data_oe ? host_data_out : 32'h0);
	modport device (
		input  chip_select_n, data_strobe_a, data_strobe_b,
		input  direction_input, register_select_code, host_data_bus,
		output dev_data_out, dev_data_oe, ready_output
	);
	modport host (
		output chip_select_n, data_strobe_a, data_strobe_b,
		output direction_input, register_select_code,
		output host_data_out, host_data_oe,
		input  host_data_bus, ready_output
	);
endinterface // host_port_if
`default_nettype wire

//--- design/host_port_device.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module host_port_device (
	// clock and reset
	input  wire logic    clk,
	input  wire logic    rst,
	// link
	host_port_if.device  hp,
	// status
	output logic [2:0]   port_control_reg,
	output logic [31:0]  read_address_reg,
	output logic [31:0]  write_address_reg,
	output logic         busy
);
	// read path idle, fetch, hold; data writes pass through store
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_FETCH = 3'b001,
		S_HOLD = 3'b011,
		S_STORE = 3'b010
	} dev_state_t;
	// whole state of the port in one register
	typedef struct packed {
		dev_state_t  st;
		logic        strobe;
		logic [1:0]  sel;
		logic        rd;
		logic [2:0]  ctl;
		logic [31:0] ara;
		logic [31:0] awa;
		logic [31:0] data;
		logic        oe;
		logic        rdy_n;
		logic [1:0]  cnt;
		logic        pend;
		logic        act;
		logic        busy;
	} dev_t;
	dev_t r, n;
	logic [31:0] mem [host_port_pkg::MEM_WORDS];
	logic        strobe_now;
	logic        fall;
	logic        rise;
	logic        dual;
	logic        use_rd;
	logic        mem_we;
	logic [31:0] mem_q;
	logic        take;
	assign strobe_now = ~hp.chip_select_n &
		(hp.data_strobe_a ^ hp.data_strobe_b);
	// edges taken against last cycle's strobe level
	assign fall = strobe_now & ~r.strobe;
	assign rise = ~strobe_now & r.strobe;
	// dual mode off: both address registers act as one
	assign dual = r.ctl[host_port_pkg::DUAL_MODE_POS];
	assign use_rd = ~dual | r.ctl[host_port_pkg::ADDR_SELECT_POS];
	// store pulse one cycle after the rising strobe
	assign mem_we = (r.st == S_STORE) && (r.cnt == 2'h0);
	// a strobe that meets a busy port waits for idle
	// so stale controls of the last access are never reused
	assign take = strobe_now & (r.st == S_IDLE) &
		(fall | r.pend);
	// no reset on the array: its contents belong to the host
	always_ff @(posedge clk) begin
		if (mem_we)
			mem[r.awa[host_port_pkg::MEM_AW+1:2]] <= r.data;
		mem_q <= mem[r.ara[host_port_pkg::MEM_AW+1:2]];
	end
	always_comb begin
		n = r;
		n.strobe = strobe_now;
		// one down counter serves the fetch latency
		if (n.cnt != 2'h0)
			n.cnt = r.cnt - 2'h1;
		// capture on falling strobe
		// controls stay put for the whole strobe, so a late take is safe
		if (take) begin
			n.act = 1'b1;
			n.sel = hp.register_select_code;
			n.rd = hp.direction_input;
			if (hp.direction_input) begin
				n.oe = 1'b1;
				unique case (hp.register_select_code)
					host_port_pkg::SEL_CTL: begin
						// only the three control bits exist
						n.data = {29'h0, r.ctl};
						n.rdy_n = 1'b0;
					end
					host_port_pkg::SEL_ADDR: begin
						n.data = use_rd ? r.ara : r.awa;
						n.rdy_n = 1'b0;
					end
					default: begin
						n.st = S_FETCH;
						// latency covers the registered array read
						n.cnt = host_port_pkg::MEM_LAT_CNT;
						n.rdy_n = 1'b1;
					end
				endcase
			end else begin
				n.rdy_n = 1'b0;
			end
		end
		if (r.st == S_FETCH && r.cnt == 2'h0) begin
			n.data = mem_q;
			n.rdy_n = 1'b0;
			n.st = S_HOLD;
		end
		// a rise with no captured access is ignored
		if (rise && r.act) begin
			n.act = 1'b0;
			n.oe = 1'b0;
			if (!r.rd) begin
				unique case (r.sel)
					host_port_pkg::SEL_CTL:
						n.ctl = hp.host_data_bus[2:0];
					host_port_pkg::SEL_ADDR: begin
						if (use_rd)
							n.ara = hp.host_data_bus;
						if (!dual || !r.ctl[host_port_pkg::ADDR_SELECT_POS])
							n.awa = hp.host_data_bus;
					end
					default: begin
						n.data = hp.host_data_bus;
						n.st = S_STORE;
						n.cnt = 2'h0;
						n.rdy_n = 1'b1;
					end
				endcase
			end else if (r.st == S_HOLD) begin
				// read side bumps only after its data left the port
				n.st = S_IDLE;
				if (r.sel == host_port_pkg::SEL_DATA_INC) begin
					n.ara = r.ara + 32'h4;
					if (!dual)
						n.awa = r.awa + 32'h4;
				end
			end
		end
		// increment only after the store has used the old address
		if (r.st == S_STORE) begin
			n.st = S_IDLE;
			n.rdy_n = 1'b0;
			if (r.sel == host_port_pkg::SEL_DATA_INC) begin
				n.awa = r.awa + 32'h4;
				if (!dual)
					n.ara = r.ara + 32'h4;
			end
		end
		// not ready while a strobe waits for capture
		n.pend = (fall | r.pend) & strobe_now & ~take;
		if (n.pend)
			n.rdy_n = 1'b1;
		else if (!n.act && n.st == S_IDLE)
			n.rdy_n = 1'b0;
		// registered so the status output comes from a flop
		n.busy = (n.st != S_IDLE);
		if (hp.chip_select_n)
			n.rdy_n = 1'b0;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '{
				st:     S_IDLE,
				strobe: 1'b0,
				sel:    2'h0,
				rd:     1'b0,
				ctl:    host_port_pkg::CTL_RESET,
				ara:    host_port_pkg::ADDR_RESET,
				awa:    host_port_pkg::ADDR_RESET,
				data:   32'h0,
				oe:     1'b0,
				rdy_n:  1'b0,
				cnt:    2'h0,
				pend:   1'b0,
				act:    1'b0,
				busy:   1'b0
			};
		end else begin
			r <= n;
		end
	end
	// link outputs
	// ready low completes cycle
	assign hp.ready_output = r.rdy_n;
	assign hp.dev_data_out = r.data;
	assign hp.dev_data_oe = r.oe;
	// status outputs
	assign port_control_reg = r.ctl;
	assign read_address_reg = r.ara;
	assign write_address_reg = r.awa;
	assign busy = r.busy;
endmodule // host_port_device
`default_nettype wire

//--- design/host_port_host.sv
`timescale 1ns/1ns
`default_nettype none
module host_port_host (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// user request
	input  wire logic        req,
	input  wire logic [1:0]  req_sel,
	input  wire logic        req_read,
	input  wire logic [31:0] req_wdata,
	// user answer
	output logic             done,
	output logic [31:0]      rdata,
	output logic             idle,
	// link
	host_port_if.host        hp
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SETUP = 2'b01,
		H_WAIT = 2'b11,
		H_END = 2'b10
	} host_state_t;
	typedef struct packed {
		host_state_t st;
		logic        cs_n;
		logic        strb_n;
		logic        rd;
		logic [1:0]  sel;
		logic [31:0] wd;
		logic        oe;
		logic [1:0]  cnt;
		logic        done;
		logic [31:0] rdata;
		logic        idle;
	} host_t;
	host_t r, n;
	always_comb begin
		n = r;
		n.done = 1'b0;
		if (r.cnt != 2'h0)
			n.cnt = r.cnt - 2'h1;
		unique case (r.st)
			H_IDLE: if (req) begin
				n.cs_n = 1'b0;
				n.sel = req_sel;
				n.rd = req_read;
				n.wd = (req_sel == host_port_pkg::SEL_ADDR) ?
					{req_wdata[31:2], 2'h0} : req_wdata;
				n.oe = ~req_read;
				n.st = H_SETUP;
			end
			H_SETUP: begin
				n.strb_n = 1'b0;
				n.cnt = host_port_pkg::STROBE_HALF_CNT;
				n.st = H_WAIT;
			end
			H_WAIT: if (r.cnt == 2'h0 && !hp.ready_output) begin
				if (r.rd)
					n.rdata = hp.host_data_bus;
				n.strb_n = 1'b1;
				n.st = H_END;
			end
			default: begin
				n.cs_n = 1'b1;
				n.oe = 1'b0;
				n.done = 1'b1;
				n.st = H_IDLE;
			end
		endcase
		n.idle = (n.st == H_IDLE);
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '{st: H_IDLE, cs_n: 1'b1, strb_n: 1'b1, sel: 2'h0,
				wd: 32'h0, cnt: 2'h0, rdata: 32'h0, idle: 1'b1,
				default: 1'b0};
		end else begin
			r <= n;
		end
	end
	assign hp.chip_select_n = r.cs_n;
	assign hp.data_strobe_a = r.strb_n;
	assign hp.data_strobe_b = 1'b1;
	assign hp.direction_input = r.rd;
	assign hp.register_select_code = r.sel;
	assign hp.host_data_out = r.wd;
	assign hp.host_data_oe = r.oe;
	assign done = r.done;
	assign rdata = r.rdata;
	assign idle = r.idle;
endmodule // host_port_host
`default_nettype wire

//--- testbench/host_port_chk.sv
`timescale 1ns/1ns
`default_nettype none
module host_port_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// host side
	input wire logic        chip_select_n,
	input wire logic        data_strobe_a,
	input wire logic        data_strobe_b,
	input wire logic        direction_input,
	input wire logic [1:0]  register_select_code,
	input wire logic [31:0] host_data_bus,
	// device side
	input wire logic        dev_data_oe,
	input wire logic        ready_output
);
	logic stb;
	// high while the internal strobe is active
	assign stb = !chip_select_n && (data_strobe_a ^ data_strobe_b);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_ready_deselect: assert property (
		chip_select_n [*2] |-> !ready_output)
		else $error("ready held while deselected");
	chk_strobe_select: assert property (
		(data_strobe_a ^ data_strobe_b) |-> !chip_select_n)
		else $error("data strobe active while deselected");
	chk_strobe_tied: assert property (data_strobe_b)
		else $error("unused strobe input not tied high");
	chk_read_wait: assert property (
		$rose(stb) && direction_input && register_select_code[0]
		|=> ready_output)
		else $error("data read not held off during fetch");
	chk_ctl_steady: assert property (
		stb && $past(stb) |->
		$stable(register_select_code) && $stable(direction_input))
		else $error("controls moved during strobe");
	chk_wdata_steady: assert property (
		stb && $past(stb) && !direction_input |-> $stable(host_data_bus))
		else $error("write data moved during strobe");
	chk_strobe_width: assert property ($rose(stb) |-> stb [*3])
		else $error("strobe shorter than three cycles");
	chk_release_ready: assert property (
		$fell(stb) |-> !$past(ready_output))
		else $error("strobe released while ready said wait");
	chk_read_driven: assert property (
		$fell(stb) && direction_input |-> $past(dev_data_oe))
		else $error("read ended with bus not driven");
endmodule // host_port_chk
`default_nettype wire

//--- testbench/host_port_address_and_strobe_tb.sv
`timescale 1ns/1ns
`default_nettype none
module host_port_address_and_strobe_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        req = 1'b0;
	logic [1:0]  req_sel = 2'h0;
	logic        req_read = 1'b0;
	logic [31:0] req_wdata = 32'h0;
	logic        done, idle, busy;
	logic [31:0] rdata, ar, aw, ear, eaw, a;
	logic [31:0] mem [256];
	logic [2:0]  ctl, ectl, c;
	int          error_cnt = 0;
	int          n_compared = 0;
	host_port_if hp ();
	always #10 clk = ~clk;
	host_port_device u_host_port_device (.clk(clk), .rst(rst),
		.hp(hp), .port_control_reg(ctl), .read_address_reg(ar),
		.write_address_reg(aw), .busy(busy));
	host_port_host u_host_port_host (.clk(clk), .rst(rst),
		.req(req), .req_sel(req_sel), .req_read(req_read),
		.req_wdata(req_wdata), .done(done), .rdata(rdata),
		.idle(idle), .hp(hp));
	host_port_chk u_host_port_chk (.clk(clk), .rst(rst),
		.chip_select_n(hp.chip_select_n),
		.data_strobe_a(hp.data_strobe_a),
		.data_strobe_b(hp.data_strobe_b),
		.direction_input(hp.direction_input),
		.register_select_code(hp.register_select_code),
		.host_data_bus(hp.host_data_bus),
		.dev_data_oe(hp.dev_data_oe), .ready_output(hp.ready_output));
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one host access; the model is updated once done is seen, before the checks
	task automatic step(input logic [1:0] s, input logic r,
		input logic [31:0] d);
		logic [31:0] e;
		logic        du;
		du = ectl[1];
		e = {29'h0, ectl};
		while (idle !== 1'b1 || busy !== 1'b0) @(negedge clk);
		@(posedge clk);
		req <= 1'b1;
		req_sel <= s;
		req_read <= r;
		req_wdata <= d;
		@(posedge clk);
		req <= 1'b0;
		for (int n = 0; n < 300 && done !== 1'b1; n++) @(negedge clk);
		if (done !== 1'b1) error_cnt++;
		if (s == host_port_pkg::SEL_CTL && !r) ectl = d[2:0];
		if (s == host_port_pkg::SEL_ADDR) begin
			e = (du && !ectl[2]) ? eaw : ear;
			if (!r && (!du || ectl[2])) ear = d;
			if (!r && (!du || !ectl[2])) eaw = d;
		end
		if (s[0]) begin
			e = mem[ear[9:2]];
			if (!r) mem[eaw[9:2]] = d;
			if (s == host_port_pkg::SEL_DATA_INC) begin
				if (r || !du) ear = ear + 32'h4;
				if (!r || !du) eaw = eaw + 32'h4;
			end
		end
		while (busy !== 1'b0) @(negedge clk);
		@(negedge clk);
		if (r) chk(rdata, e);
		chk(ar, ear);
		chk(aw, eaw);
		chk({29'h0, ctl}, {29'h0, ectl});
	endtask
	initial begin
		void'($urandom(32'h83dbeb1d));
		ear = 32'h0;
		eaw = 32'h0;
		ectl = 3'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(ar, ear);
		chk({29'h0, ctl}, 32'h0);
		step(host_port_pkg::SEL_ADDR, 1'b0, 32'h0);
		// fill every word so later reads have a known value
		for (int i = 0; i < 256; i++)
			step(host_port_pkg::SEL_DATA_INC, 1'b0, $urandom);
		$display("test fill done");
		for (int t = 0; t < 24; t++) begin
			a = (t == 0) ? 32'hfffffffc : ($urandom & 32'hfffffffc);
			c = 3'($urandom);
			step(host_port_pkg::SEL_CTL, 1'b0, {29'h0, c | 3'h4});
			step(host_port_pkg::SEL_ADDR, 1'b0, a);
			step(host_port_pkg::SEL_CTL, 1'b0, {29'h0, c & 3'h3});
			step(host_port_pkg::SEL_ADDR, 1'b0, a);
			step(host_port_pkg::SEL_CTL, 1'b0, {29'h0, c});
			repeat (4) step({1'($urandom), 1'b1}, 1'b0, $urandom);
			step(host_port_pkg::SEL_ADDR, 1'b0, a);
			repeat (4) step({1'($urandom), 1'b1}, 1'b1, 32'h0);
			step(host_port_pkg::SEL_ADDR, 1'b1, 32'h0);
			step(host_port_pkg::SEL_CTL, 1'b1, 32'h0);
			$display("test %0d done", t);
		end
		end_sim();
	end
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		end_sim();
	end
endmodule // host_port_address_and_strobe_tb
`default_nettype wire
